/* File: logic/oag_consts.svh */
`ifndef OAG_CONSTS_SVH
`define OAG_CONSTS_SVH

// Address space windows and forcing patterns
`define OAG_SADDR_HIGH      7'h7f
`define OAG_SADDR_LOW_LIMIT 8'h20
`define OAG_SFR_HIGH        8'hff
`define OAG_ZERO_BYTE       8'h00

// Register codes inside one bank
`define OAG_REG_X 3'h0
`define OAG_REG_A 3'h1
`define OAG_REG_C 3'h2
`define OAG_REG_B 3'h3
`define OAG_REG_E 3'h4
`define OAG_REG_D 3'h5
`define OAG_REG_L 3'h6
`define OAG_REG_H 3'h7

// Pair codes
`define OAG_PAIR_ACC  2'h0
`define OAG_PAIR_SEC  2'h1
`define OAG_PAIR_PTRD 2'h2
`define OAG_PAIR_BASE 2'h3

`endif

/* File: logic/oag_pkg.sv */
package oag_pkg;

    // Operand address mode requested by the decoder
    typedef enum logic [3:0]
    {
        OAG_MODE_NONE      = 4'h0,
        OAG_MODE_JUMP_ACC  = 4'h1,
        OAG_MODE_IMPLIED   = 4'h2,
        OAG_MODE_REG       = 4'h3,
        OAG_MODE_REG_PAIR  = 4'h4,
        OAG_MODE_DIRECT    = 4'h5,
        OAG_MODE_SHORT     = 4'h6,
        OAG_MODE_SFR       = 4'h7,
        OAG_MODE_INDIRECT  = 4'h8,
        OAG_MODE_BASED     = 4'h9,
        OAG_MODE_BASED_IDX = 4'ha,
        OAG_MODE_STACK     = 4'hb
    } oag_mode_t;

    // Implied operation selector
    typedef enum logic [2:0]
    {
        OAG_IMP_MULTIPLY = 3'h0,
        OAG_IMP_DIVIDE   = 3'h1,
        OAG_IMP_ADJ_ADD  = 3'h2,
        OAG_IMP_ADJ_SUB  = 3'h3,
        OAG_IMP_ROT_R    = 3'h4,
        OAG_IMP_ROT_L    = 3'h5
    } oag_implied_t;

    // Request from the instruction decoder
    typedef struct packed
    {
        logic         valid;
        oag_mode_t    mode;
        oag_implied_t implied_op;
        logic [2:0]   reg_code;
        logic [1:0]   pair_code;
        logic         index_is_b;
        logic [15:0]  imm16;
        logic [7:0]   imm8;
    } oag_req_t;

    // Result towards memory bus, register file and program counter
    typedef struct packed
    {
        logic         valid;
        logic         mem_access;
        logic [15:0]  mem_addr;
        logic         reg_access;
        logic [4:0]   reg_index;
        logic         pair_access;
        logic [3:0]   pair_index;
        logic         pc_load;
        logic [15:0]  pc_value;
        logic [4:0]   src_index;
        logic [4:0]   dst_index;
        logic         dst_is_pair;
    } oag_resp_t;

endpackage : oag_pkg

/* File: logic/oag_operand_address.sv */
`timescale 1ns/1ps
`include "oag_consts.svh"

// Function
// - Jump through accumulator pair loads its full 16 bits into the program counter.
// - Multiply takes accumulator as multiplicand, X as operand, product to accumulator pair.
// - Word divide uses accumulator pair as dividend and quotient, with no field.
// - Decimal adjust and nibble rotate implicitly act on the accumulator.
// - Register operand picks one of eight via 3-bit code in the selected bank.
// - Codes 0..7 are X,A,C,B,E,D,L,H; pair codes 0..3 accumulator, second, pointer, base.
// - Direct mode uses the 16-bit immediate as address anywhere.
// - Short direct reaches only the 256-byte window FE20H to FF1FH.
// - Short direct bit 8 is low for 20H..FFH, high for 00H..1FH.
// - Special register mode reaches FF00H..FFCFH and FFE0H..FFFFH by 8-bit immediate.
// - Register indirect uses the current bank's pointer or base pair as address.
// - Based mode adds zero-extended byte offset to base pair, carry discarded.
// - Based indexed adds zero-extended B or C to base pair, carry discarded.
// - Push, pop, call, return and interrupt saves address memory through stack pointer.
module oag_operand_address
    import oag_pkg::*;
#(
    // Address and register file geometry
    parameter int unsigned ADDR_W   = 16,
    parameter int unsigned BANK_CNT = 4,
    parameter int unsigned REG_CNT  = 8
)
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Decoder request
    input  wire oag_req_t    req_i,
    // Program status bank select flags
    input  wire logic        bank_select_low_i,
    input  wire logic        bank_select_high_i,
    // Register file contents of the active bank, plus the unbanked stack pointer
    input  wire logic [15:0] accumulator_pair_i,
    input  wire logic [15:0] second_pair_i,
    input  wire logic [15:0] pointer_pair_d_i,
    input  wire logic [15:0] base_pair_i,
    input  wire logic [15:0] stack_pointer_i,
    // Result
    output oag_resp_t        resp_o
);

    //**********************************************************
    // Elaboration checks
    //**********************************************************

    // The request and result structs fix these sizes; other values cannot be served
    if (ADDR_W != 16)
    begin : g_bad_addr_w
        $error("address width must be 16");
    end
    if (BANK_CNT != 4)
    begin : g_bad_bank_cnt
        $error("bank count must be 4");
    end
    if (REG_CNT != 8)
    begin : g_bad_reg_cnt
        $error("register count per bank must be 8");
    end

    //**********************************************************
    // Helpers
    //**********************************************************

    // Flat register file index: bank in the top bits, code below
    function automatic logic [4:0] reg_idx(input logic [1:0] bank_sel,
                                           input logic [2:0] code);
        reg_idx = {bank_sel, code};
    endfunction : reg_idx

    // Flat pair index, same layout as the register index
    function automatic logic [3:0] pair_idx(input logic [1:0] bank_sel,
                                            input logic [1:0] code);
        pair_idx = {bank_sel, code};
    endfunction : pair_idx

    // Zero extension plus 16-bit wrap; the carry is simply not kept
    function automatic logic [15:0] add_wrap(input logic [15:0] base,
                                             input logic [7:0]  off);
        logic [16:0] sum;
        sum      = {1'b0, base} + {9'h000, off};
        add_wrap = sum[15:0];
    endfunction : add_wrap

    // Short direct: bits 15..9 forced high, bit 8 folds low immediates upward
    function automatic logic [15:0] short_addr(input logic [7:0] imm);
        logic fold;
        fold       = (imm < `OAG_SADDR_LOW_LIMIT);
        short_addr = {`OAG_SADDR_HIGH, fold, imm};
    endfunction : short_addr

    // Special register: high byte all ones, immediate in the low byte
    function automatic logic [15:0] sfr_addr(input logic [7:0] imm);
        sfr_addr = {`OAG_SFR_HIGH, imm};
    endfunction : sfr_addr

    //**********************************************************
    // Operand sources
    //**********************************************************

    logic [1:0]  bank;
    logic [7:0]  index_byte;
    logic [15:0] pointer_addr;
    logic [15:0] based_addr;
    logic [15:0] indexed_addr;
    oag_resp_t   resp_reg;
    oag_resp_t   resp_next;

    // Bank flags come from the status word on this clock, so no synchroniser
    assign bank = {bank_select_high_i, bank_select_low_i};

    // B sits in the high byte of the second pair, C in the low byte
    assign index_byte = req_i.index_is_b ? second_pair_i[15:8]
                                         : second_pair_i[7:0];

    // Only the pointer code picks the pointer pair; any other code means base
    assign pointer_addr = (req_i.pair_code == `OAG_PAIR_PTRD) ? pointer_pair_d_i
                                                               : base_pair_i;

    // Both sums wrap at 16 bits, so a base near the top lands at the bottom
    assign based_addr   = add_wrap(base_pair_i, req_i.imm8);
    assign indexed_addr = add_wrap(base_pair_i, index_byte);

    //**********************************************************
    // Address formation
    //**********************************************************

    // One mode per request; registered so data outputs come from flops
    always_comb
    begin
        resp_next       = '0;
        resp_next.valid = req_i.valid;
        if (req_i.valid)
        begin
            unique case (req_i.mode)
                // Jump through the accumulator pair: the whole pair is the target
                OAG_MODE_JUMP_ACC:
                begin
                    resp_next.pc_load  = 1'b1;
                    resp_next.pc_value = accumulator_pair_i;
                end
                // Implied operands: the operation names them, no field does
                OAG_MODE_IMPLIED:
                begin
                    resp_next.reg_access = 1'b1;
                    unique case (req_i.implied_op)
                        OAG_IMP_MULTIPLY:
                        begin
                            resp_next.src_index   = reg_idx(bank, `OAG_REG_X);
                            resp_next.dst_index   = reg_idx(bank, `OAG_REG_A);
                            resp_next.dst_is_pair = 1'b1;
                        end
                        OAG_IMP_DIVIDE:
                        begin
                            resp_next.src_index   = reg_idx(bank, `OAG_REG_X);
                            resp_next.dst_index   = reg_idx(bank, `OAG_REG_X);
                            resp_next.dst_is_pair = 1'b1;
                        end
                        default:
                        begin
                            // Adjust and rotate act on the accumulator byte
                            resp_next.src_index = reg_idx(bank, `OAG_REG_A);
                            resp_next.dst_index = reg_idx(bank, `OAG_REG_A);
                        end
                    endcase
                end
                // Byte register inside the active bank
                OAG_MODE_REG:
                begin
                    resp_next.reg_access = 1'b1;
                    resp_next.reg_index  = reg_idx(bank, req_i.reg_code);
                end
                // Register pair inside the active bank
                OAG_MODE_REG_PAIR:
                begin
                    resp_next.pair_access = 1'b1;
                    resp_next.pair_index  = pair_idx(bank, req_i.pair_code);
                end
                // Full 16-bit address straight from the instruction
                OAG_MODE_DIRECT:
                begin
                    resp_next.mem_access = 1'b1;
                    resp_next.mem_addr   = req_i.imm16;
                end
                // Low immediates fold onto FF00H..FF1FH, others onto FE20H..FEFFH
                OAG_MODE_SHORT:
                begin
                    resp_next.mem_access = 1'b1;
                    resp_next.mem_addr   = short_addr(req_i.imm8);
                end
                // FFD0H..FFDFH is not decoded out; the decoder never emits it
                OAG_MODE_SFR:
                begin
                    resp_next.mem_access = 1'b1;
                    resp_next.mem_addr   = sfr_addr(req_i.imm8);
                end
                // Pair contents used as the address, whole space reachable
                OAG_MODE_INDIRECT:
                begin
                    resp_next.mem_access = 1'b1;
                    resp_next.mem_addr   = pointer_addr;
                end
                // Base pair plus instruction offset
                OAG_MODE_BASED:
                begin
                    resp_next.mem_access = 1'b1;
                    resp_next.mem_addr   = based_addr;
                end
                // Base pair plus B or C
                OAG_MODE_BASED_IDX:
                begin
                    resp_next.mem_access = 1'b1;
                    resp_next.mem_addr   = indexed_addr;
                end
                // Range is software's duty; address passes through as is
                OAG_MODE_STACK:
                begin
                    resp_next.mem_access = 1'b1;
                    resp_next.mem_addr   = stack_pointer_i;
                end
                // No mode or an unused code: answered, but nothing is accessed
                default:
                begin
                    resp_next.valid = 1'b1;
                end
            endcase
        end
    end

    //**********************************************************
    // Output register
    //**********************************************************

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            resp_reg <= '0;
        end
        else
        begin
            resp_reg <= resp_next;
        end
    end

    assign resp_o = resp_reg;

endmodule : oag_operand_address

/* File: test/oag_operand_address_monitor.sv */
`timescale 1ns/1ps
// ****
// Address checks at the block ports
// ****
module oag_monitor
    import oag_pkg::*;
(
    // Inputs and result of the block
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire oag_req_t    req_i,
    input wire logic        bank_select_low_i,
    input wire logic        bank_select_high_i,
    input wire logic [15:0] accumulator_pair_i,
    input wire logic [15:0] second_pair_i,
    input wire logic [15:0] pointer_pair_d_i,
    input wire logic [15:0] base_pair_i,
    input wire logic [15:0] stack_pointer_i,
    input wire oag_resp_t   resp_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    // A request of one mode, answered one cycle later
    sequence s_req(oag_mode_t m);
        req_i.valid && req_i.mode == m;
    endsequence
    sequence s_mem;
        resp_o.valid && resp_o.mem_access;
    endsequence
    logic [15:0] addr;
    assign addr = resp_o.mem_addr;
    a_jump_pc:
    assert property (s_req(OAG_MODE_JUMP_ACC) |=> resp_o.pc_load
        && resp_o.pc_value == $past(accumulator_pair_i)) else $error("jump target wrong");
    a_direct_addr:
    assert property (s_req(OAG_MODE_DIRECT) |-> ##1 s_mem and addr == $past(req_i.imm16))
        else $error("direct address wrong");
    a_short_addr:
    assert property (s_req(OAG_MODE_SHORT) |=> s_mem
        and addr == {7'h7f, $past(req_i.imm8) < 8'h20, $past(req_i.imm8)})
        else $error("short direct address wrong");
    a_sfr_addr:
    assert property (s_req(OAG_MODE_SFR) |=> addr == {8'hff, $past(req_i.imm8)})
        else $error("special register address wrong");
    a_indirect_addr:
    assert property (s_req(OAG_MODE_INDIRECT) |=> addr == ($past(req_i.pair_code) == 2'h2
        ? $past(pointer_pair_d_i) : $past(base_pair_i))) else $error("indirect address wrong");
    a_based_addr:
    assert property (s_req(OAG_MODE_BASED) |=> addr == $past(base_pair_i)
        + {8'h00, $past(req_i.imm8)}) else $error("based address wrong");
    a_based_index:
    assert property (s_req(OAG_MODE_BASED_IDX) |=> addr == $past(base_pair_i) + {8'h00,
        $past(req_i.index_is_b) ? $past(second_pair_i[15:8]) : $past(second_pair_i[7:0])})
        else $error("based indexed address wrong");
    a_stack_addr:
    assert property (s_req(OAG_MODE_STACK) |=> s_mem and addr == $past(stack_pointer_i))
        else $error("stack address wrong");
    a_reg_select:
    assert property (s_req(OAG_MODE_REG) |=> resp_o.reg_access && resp_o.reg_index ==
        {$past(bank_select_high_i), $past(bank_select_low_i), $past(req_i.reg_code)})
        else $error("register select wrong");
    a_multiply_src:
    assert property (s_req(OAG_MODE_IMPLIED) ##0 req_i.implied_op == OAG_IMP_MULTIPLY
        |=> resp_o.dst_is_pair && resp_o.src_index[2:0] == 3'h0) else $error("multiply wrong");
endmodule : oag_monitor

bind oag_operand_address oag_monitor i_mon (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
    .bank_select_low_i(bank_select_low_i), .bank_select_high_i(bank_select_high_i),
    .accumulator_pair_i(accumulator_pair_i), .second_pair_i(second_pair_i),
    .pointer_pair_d_i(pointer_pair_d_i), .base_pair_i(base_pair_i),
    .stack_pointer_i(stack_pointer_i), .resp_o(resp_o));

/* File: test/oag_regfile_model.sv */
`timescale 1ns/1ps
// ****
// Banked register file feeding the pair inputs
// ****
module oag_regfile_model
(
    // Write side driven by the bench
    input  wire logic        clk_i,
    input  wire logic        wr_en_i,
    input  wire logic [2:0]  wr_sel_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic [1:0]  bank_i,
    // Contents of the selected bank, plus the unbanked stack pointer
    output logic [15:0]      acc_o,
    output logic [15:0]      sec_o,
    output logic [15:0]      ptr_o,
    output logic [15:0]      base_o,
    output logic [15:0]      sp_o
);
    logic [15:0] pair_reg [16];
    logic [15:0] sp_reg;
    // Pair writes land in the selected bank only, so a bank switch shows other contents; the stack pointer is shared
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i && wr_sel_i[2])
            sp_reg <= wr_data_i;
        else if (wr_en_i)
            pair_reg[{bank_i, wr_sel_i[1:0]}] <= wr_data_i;
    end
    // Pair codes 0 to 3 within the active bank
    assign acc_o  = pair_reg[{bank_i, 2'h0}];
    assign sec_o  = pair_reg[{bank_i, 2'h1}];
    assign ptr_o  = pair_reg[{bank_i, 2'h2}];
    assign base_o = pair_reg[{bank_i, 2'h3}];
    assign sp_o   = sp_reg;
endmodule : oag_regfile_model

/* File: test/test_operand_address_generator.sv */
`timescale 1ns/1ps
// ****
// Bench
// ****
module test_operand_address_generator;
    import oag_pkg::*;
    logic        clk_i;
    logic        resetn_i;
    oag_req_t    req_i;
    oag_resp_t   resp_o;
    logic [1:0]  bank;
    logic        wr_en;
    logic [2:0]  wr_sel;
    logic [15:0] wr_data;
    logic [15:0] acc_w, sec_w, ptr_w, base_w, sp;
    int          n_fail;
    int          tests_run;

    oag_regfile_model i_regs (.clk_i(clk_i), .wr_en_i(wr_en), .wr_sel_i(wr_sel),
        .wr_data_i(wr_data), .bank_i(bank), .acc_o(acc_w), .sec_o(sec_w), .ptr_o(ptr_w),
        .base_o(base_w), .sp_o(sp));
    oag_operand_address i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
        .bank_select_low_i(bank[0]), .bank_select_high_i(bank[1]), .accumulator_pair_i(acc_w),
        .second_pair_i(sec_w), .pointer_pair_d_i(ptr_w), .base_pair_i(base_w),
        .stack_pointer_i(sp),
        .resp_o(resp_o));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request goes out at a falling edge; the answer is read one cycle later
    task issue(input oag_mode_t m, input logic [15:0] i16, input logic [7:0] i8,
               input logic [2:0] rc);
        @(negedge clk_i);
        req_i = '{valid: 1'b1, mode: m, implied_op: oag_implied_t'(rc), reg_code: rc,
                  pair_code: rc[1:0], index_is_b: rc[0], imm16: i16, imm8: i8};
        @(negedge clk_i);
    endtask : issue
    task mem(input oag_mode_t m, input logic [15:0] i16, input logic [7:0] i8,
             input logic [2:0] rc, input logic [15:0] e);
        issue(m, i16, i8, rc);
        chk({resp_o.valid, resp_o.mem_access, resp_o.mem_addr}, {2'h3, e});
    endtask : mem
    task wr(input logic [2:0] sel, input logic [15:0] data);
        @(negedge clk_i);
        wr_en = 1'b1;
        wr_sel = sel;
        wr_data = data;
        @(negedge clk_i);
        wr_en = 1'b0;
    endtask : wr
    // Window edges of the fixed-space modes
    task t_windows();
        mem(OAG_MODE_SHORT, 16'h0000, 8'h00, 3'h0, 16'hff00);
        mem(OAG_MODE_SHORT, 16'h0000, 8'h1f, 3'h0, 16'hff1f);
        mem(OAG_MODE_SHORT, 16'h0000, 8'h20, 3'h0, 16'hfe20);
        mem(OAG_MODE_SHORT, 16'h0000, 8'hff, 3'h0, 16'hfeff);
        mem(OAG_MODE_SFR, 16'h0000, 8'hcf, 3'h0, 16'hffcf);
        mem(OAG_MODE_SFR, 16'h0000, 8'he0, 3'h0, 16'hffe0);
        mem(OAG_MODE_SHORT, 16'h0000, 8'h1e, 3'h0, 16'hff1e);
        mem(OAG_MODE_SFR, 16'h0000, 8'h20, 3'h0, 16'hff20);
        mem(OAG_MODE_DIRECT, 16'hffff, 8'h00, 3'h0, 16'hffff);
        mem(OAG_MODE_DIRECT, 16'h0001, 8'hff, 3'h0, 16'h0001);
    endtask : t_windows
    // Pointer modes, with sums that carry out of 16 bits
    task t_pointers();
        wr(3'h1, 16'hff01);
        wr(3'h2, 16'h1234);
        wr(3'h3, 16'hfff0);
        wr(3'h4, 16'hfe80);
        mem(OAG_MODE_INDIRECT, 16'h0000, 8'h00, 3'h2, 16'h1234);
        mem(OAG_MODE_INDIRECT, 16'h0000, 8'h00, 3'h3, 16'hfff0);
        mem(OAG_MODE_BASED, 16'h0000, 8'h20, 3'h0, 16'h0010);
        mem(OAG_MODE_BASED_IDX, 16'h0000, 8'h00, 3'h1, 16'h00ef);
        mem(OAG_MODE_BASED_IDX, 16'h0000, 8'h00, 3'h0, 16'hfff1);
        mem(OAG_MODE_STACK, 16'h0000, 8'h00, 3'h0, 16'hfe80);
        @(negedge clk_i) bank = 2'h3;
        wr(3'h3, 16'h0100);
        mem(OAG_MODE_INDIRECT, 16'h0000, 8'h00, 3'h3, 16'h0100);
        wr(3'h0, 16'hbeef);
        issue(OAG_MODE_JUMP_ACC, 16'h0000, 8'h00, 3'h0);
        chk({resp_o.pc_load, resp_o.pc_value}, {1'b1, 16'hbeef});
    endtask : t_pointers
    // Every register and pair code in every bank
    task t_register();
        for (int b = 0; b < 4; b++)
        begin
            @(negedge clk_i) bank = b[1:0];
            for (int c = 0; c < 8; c++)
            begin
                issue(OAG_MODE_REG, 16'h0000, 8'h00, c[2:0]);
                chk({resp_o.reg_access, resp_o.reg_index}, {1'b1, b[1:0], c[2:0]});
                issue(OAG_MODE_REG_PAIR, 16'h0000, 8'h00, c[2:0]);
                chk({resp_o.pair_access, resp_o.pair_index}, {1'b1, b[1:0], c[1:0]});
            end
        end
    endtask : t_register
    // Implied operands in bank 3
    task t_implied();
        logic [10:0] e;
        for (int k = 0; k < 6; k++)
        begin
            issue(OAG_MODE_IMPLIED, 16'h0000, 8'h00, k[2:0]);
            e = (k == 0) ? 11'h719 : (k == 1) ? 11'h718 : 11'h339;
            chk({resp_o.dst_is_pair, resp_o.src_index, resp_o.dst_index}, e);
        end
    endtask : t_implied
    task results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Whole run needs a few hundred cycles; this allows ten thousand
    initial
    begin
        #50000;
        n_fail++;
        results();
    end
    initial
    begin
        n_fail = 0;
        tests_run = 0;
        resetn_i = 1'b0;
        req_i = '0;
        bank = 2'h0;
        wr_en = 1'b0;
        wr_sel = 3'h0;
        wr_data = 16'h0000;
        repeat (12) @(posedge clk_i);
        @(negedge clk_i) resetn_i = 1'b1;
        t_windows();
        t_pointers();
        t_register();
        t_implied();
        results();
    end
endmodule : test_operand_address_generator
